// ==== bench/crl_properties.sv ====
`timescale 1ns/1ps
module crl_properties (
  // clock and reset
  input wire logic                    mclk,
  input wire logic                    rst_n,
  // strap and request
  input wire logic                    source_map_strap,
  input wire logic                    req_valid,
  input wire cmp_logic_pkg::request_t req,
  // answer
  input wire logic                    ans_valid,
  input wire cmp_logic_pkg::answer_t  ans
);
  logic [1:0]         up;
  logic               tk;
  cmp_logic_pkg::op_t op;

  // edges since release; the first one still refuses requests
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
    end else if (up != 2'h2) begin
      up <= up + 2'h1;
    end
  end

  // a taken request and its operation
  assign tk = req_valid && (up != 2'h0);
  assign op = req.op;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_answer;
    tk |=> ans_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("taken request got no answer");

  property p_cmp;
    tk && op == cmp_logic_pkg::compare_op |=> ans.result == $past(req.dest) && !ans.write_back;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare altered its destination");

  property p_clr;
    tk && op == cmp_logic_pkg::acc_clear_op |=> ans.result[7:0] == 8'h00 && ans.states == 8'h01;
  endproperty
  a_clr: assert property (p_clr) else $error("clear gave wrong value");

  property p_inv;
    tk && op == cmp_logic_pkg::acc_invert_op |=> ans.result[7:0] == ~$past(req.dest[7:0]);
  endproperty
  a_inv: assert property (p_inv) else $error("invert gave wrong value");

  property p_rl;
    tk && op == cmp_logic_pkg::rotate_left_op
      |=> ans.result[7:0] == {$past(req.dest[6:0]), $past(req.dest[7])};
  endproperty
  a_rl: assert property (p_rl) else $error("rotate left wrong");

  property p_rlc;
    tk && op == cmp_logic_pkg::rotate_left_carry_op |=> ans.carry_flag == $past(req.dest[7])
      && ans.result[7:0] == {$past(req.dest[6:0]), $past(req.carry_in)};
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left with carry wrong");

  property p_rr;
    tk && op == cmp_logic_pkg::rotate_right_op
      |=> ans.result[7:0] == {$past(req.dest[0]), $past(req.dest[7:1])};
  endproperty
  a_rr: assert property (p_rr) else $error("rotate right wrong");

  property p_rrc;
    tk && op == cmp_logic_pkg::rotate_right_carry_op |=> ans.carry_flag == $past(req.dest[0])
      && ans.result[7:0] == {$past(req.carry_in), $past(req.dest[7:1])};
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right with carry wrong");

  // main scenarios reached
  c_cmp: cover property (tk && op == cmp_logic_pkg::compare_op);
  c_ext: cover property (tk && req.space == cmp_logic_pkg::space_ext);
  c_back: cover property (tk ##1 tk);
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic                    mclk;
  logic                    rst_n;
  logic                    source_map_strap;
  logic                    req_valid;
  cmp_logic_pkg::request_t req;
  logic                    ans_valid;
  cmp_logic_pkg::answer_t  ans;
  int                      num_errors;
  int                      comparisons;
  logic                    smap;
  logic                    cin;
  logic [1:0]              alt;
  logic [3:0]              ws;
  logic [31:0]             d;
  logic [31:0]             s;
  cmp_logic_pkg::space_t   sp;

  // unit under test
  compare_logic_rotate_unit dut_u (.mclk(mclk), .rst_n(rst_n),
    .source_map_strap(source_map_strap), .req_valid(req_valid), .req(req),
    .ans_valid(ans_valid), .ans(ans));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  task automatic close_out;
    $display("compares %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // reset with a map choice; a request at the first edge is refused
  task automatic do_reset;
    @(negedge mclk);
    rst_n = 1'b0;
    source_map_strap = smap;
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    req_valid = 1'b1;
    @(posedge mclk);
    #1 `CHK(ans_valid, 1'b0)
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  // one request; e holds binary length, states, then source length, states
  task automatic run(input cmp_logic_pkg::op_t o, input cmp_logic_pkg::form_t f,
                     input logic [15:0] e);
    logic [7:0] x;
    @(negedge mclk);
    req = '{op: o, form: f, alt_direct_long_addr_word: alt[0], alt_ind_word: 1'b0, alt_ind_dword: alt[1],
            space: sp, wait_states: ws, dest: d, src: s, addr: 24'h12_3456, carry_in: cin};
    req_valid = 1'b1;
    x = smap ? e[7:0] : e[15:8];
    @(posedge mclk);
    #1 `CHK({ans_valid, ans.length, ans.states}, {1'b1, x[6:4], 4'h0, x[3:0]})
  endtask

  task automatic idle;
    @(negedge mclk);
    req_valid = 1'b0;
  endtask

  task automatic scn_compare;
    d = 32'h0000_0001;
    s = 32'h0000_0003;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_dword_dword, 16'h3524);
    `CHK(ans.result, d)
    `CHK({ans.write_back, ans.carry_flag, ans.zero_flag, ans.sign_flag}, 4'h5)
    d = 32'h8000_0000;
    s = 32'h0000_0001;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_dword_dword, 16'h3524);
    `CHK({ans.carry_flag, ans.zero_flag, ans.sign_flag, ans.overflow_flag}, 4'h1)
    d = 32'hffff_1234;
    s = 32'h0000_1234;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_dword_imm1, 16'h5645);
    `CHK({ans.carry_flag, ans.zero_flag}, 2'h1)
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_dword_imm0, 16'h5645);
    `CHK({ans.carry_flag, ans.zero_flag, ans.sign_flag}, 3'h1)
    s = d;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_word_word, 16'h3322);
    `CHK(ans.zero_flag, 1'b1)
    alt = 2'h2;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_byte_byte, 16'h4433);
    `CHK(ans.addr, 24'h12_3456)
    alt = 2'h0;
    idle();
    $display("compare test done, map %0d", smap);
  endtask

  task automatic scn_penalty;
    sp = cmp_logic_pkg::space_port;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_byte_direct_short_addr, 16'h4433);
    run(cmp_logic_pkg::bitwise_or_op, cmp_logic_pkg::form_direct_short_addr_imm, 16'h3535);
    sp = cmp_logic_pkg::space_sfr;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_byte_direct_short_addr, 16'h4534);
    run(cmp_logic_pkg::bitwise_or_op, cmp_logic_pkg::form_direct_short_addr_imm, 16'h3636);
    sp = cmp_logic_pkg::space_ram;
    run(cmp_logic_pkg::bitwise_xor_op, cmp_logic_pkg::form_direct_short_addr_imm, 16'h3333);
    sp = cmp_logic_pkg::space_ext;
    ws = 4'h3;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_byte_direct_long_addr, 16'h5847);
    alt = 2'h1;
    run(cmp_logic_pkg::compare_op, cmp_logic_pkg::form_byte_direct_long_addr, 16'h5e4d);
    alt = 2'h0;
    ws = 4'h0;
    sp = cmp_logic_pkg::space_ram;
    idle();
    $display("penalty test done, map %0d", smap);
  endtask

  task automatic scn_logic;
    d = 32'h0000_f0f0;
    s = 32'h0000_ff00;
    run(cmp_logic_pkg::bitwise_and_op, cmp_logic_pkg::form_word_imm, 16'h5443);
    `CHK({ans.write_back, ans.result[15:0]}, 17'h1_f000)
    run(cmp_logic_pkg::bitwise_or_op, cmp_logic_pkg::form_word_imm, 16'h5443);
    `CHK({ans.write_back, ans.result[15:0]}, 17'h1_fff0)
    run(cmp_logic_pkg::bitwise_xor_op, cmp_logic_pkg::form_word_imm, 16'h5443);
    `CHK({ans.write_back, ans.result[15:0]}, 17'h1_0ff0)
    idle();
    $display("logic test done, map %0d", smap);
  endtask

  task automatic scn_acc;
    d = 32'h0000_0081;
    run(cmp_logic_pkg::acc_clear_op, cmp_logic_pkg::form_acc_reg, 16'h1111);
    `CHK(ans.result[7:0], 8'h00)
    run(cmp_logic_pkg::acc_invert_op, cmp_logic_pkg::form_acc_reg, 16'h1111);
    `CHK(ans.result[7:0], 8'h7e)
    run(cmp_logic_pkg::rotate_left_op, cmp_logic_pkg::form_acc_reg, 16'h1111);
    `CHK(ans.result[7:0], 8'h03)
    cin = 1'b1;
    run(cmp_logic_pkg::rotate_left_carry_op, cmp_logic_pkg::form_acc_reg, 16'h1111);
    `CHK({ans.carry_flag, ans.result[7:0]}, 9'h103)
    run(cmp_logic_pkg::rotate_right_op, cmp_logic_pkg::form_acc_reg, 16'h1111);
    `CHK(ans.result[7:0], 8'hc0)
    run(cmp_logic_pkg::rotate_right_carry_op, cmp_logic_pkg::form_acc_reg, 16'h1111);
    `CHK({ans.carry_flag, ans.result[7:0]}, 9'h1c0)
    cin = 1'b0;
    idle();
    $display("accumulator test done, map %0d", smap);
  endtask

  // both opcode maps in turn
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    source_map_strap = 1'b0;
    req_valid = 1'b0;
    req = '0;
    num_errors = 0;
    comparisons = 0;
    cin = 1'b0;
    alt = 2'h0;
    ws = 4'h0;
    d = 32'h0000_0000;
    s = 32'h0000_0000;
    sp = cmp_logic_pkg::space_ram;
    for (int m = 0; m < 2; m++) begin
      smap = m[0];
      do_reset();
      scn_compare();
      scn_penalty();
      scn_logic();
      scn_acc();
    end
    close_out();
  end

  // hang guard
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule

bind compare_logic_rotate_unit crl_properties u_props (.mclk(mclk), .rst_n(rst_n),
  .source_map_strap(source_map_strap), .req_valid(req_valid), .req(req),
  .ans_valid(ans_valid), .ans(ans));

// ==== src/cmp_logic_pkg.sv ====
// Notes on behaviour
// - compare subtracts source from destination, drops difference, only flags change
// - dword register compare: 3 bytes 5 states binary, 2 bytes 4 states source
// - zero-extend dword immediate compare fills top half with zeros; 6 or 5 states
// - one-extend dword immediate compare fills top half with ones; same timing
// - word register compare: 3 bytes 3 states binary, 2 bytes 2 states source
// - byte compare through dword pointer uses 24-bit address; 4 or 3 states
// - direct short compare operand: port adds 1 state, peripheral register adds 2; the word direct short form gets no penalty here
// - byte operand in external memory adds wait states plus two
// - word operand in external memory adds twice the sum of wait states and two
// - and, or, xor combine bitwise and write result to destination
// - 16-bit immediate bitwise into word register: 5/4 binary, 4/3 source
// - clear zeroes accumulator, invert complements it; 1 byte 1 state each
// - rotate left moves bits up, bit 7 into bit 0, carry untouched
// - rotate left through carry: bit 7 to carry, old carry to bit 0
// - rotate right moves bits down, bit 0 into bit 7, carry untouched
// - rotate right through carry: bit 0 to carry, old carry to bit 7
// - 8-bit immediate bitwise into direct byte: 3 bytes 3 states both maps
// - bitwise into direct port adds 2 states, into peripheral register adds 3
package cmp_logic_pkg;
  typedef enum logic [3:0] {
    compare_op            = 4'h0,
    bitwise_and_op        = 4'h1,
    bitwise_or_op         = 4'h2,
    bitwise_xor_op        = 4'h3,
    acc_clear_op          = 4'h4,
    acc_invert_op         = 4'h5,
    rotate_left_op        = 4'h6,
    rotate_left_carry_op  = 4'h7,
    rotate_right_op       = 4'h8,
    rotate_right_carry_op = 4'h9
  } op_t;

  // operand addressing forms
  typedef enum logic [3:0] {
    form_acc_reg    = 4'h0,
    form_acc_direct_short_addr   = 4'h1,
    form_acc_ind    = 4'h2,
    form_acc_imm    = 4'h3,
    form_direct_short_addr_acc   = 4'h4,
    form_direct_short_addr_imm   = 4'h5,
    form_byte_byte  = 4'h6,
    form_word_word  = 4'h7,
    form_dword_dword= 4'h8,
    form_byte_imm   = 4'h9,
    form_word_imm   = 4'ha,
    form_dword_imm0 = 4'hb,
    form_dword_imm1 = 4'hc,
    form_byte_direct_short_addr  = 4'hd,
    form_word_direct_short_addr  = 4'he,
    form_byte_direct_long_addr = 4'hf
  } form_t;

  // extra forms beyond four bits are carried as flags
  typedef enum logic [1:0] {
    size_byte  = 2'h0,
    size_word  = 2'h1,
    size_dword = 2'h2
  } size_t;

  typedef enum logic [1:0] {
    space_ram  = 2'h0,
    space_port = 2'h1,
    space_sfr  = 2'h2,
    space_ext  = 2'h3
  } space_t;

  typedef struct packed {
    op_t         op;
    form_t       form;
    logic        alt_direct_long_addr_word; // word register with direct long address
    logic        alt_ind_word;   // byte through word pointer
    logic        alt_ind_dword;  // byte through dword pointer
    space_t      space;
    logic [3:0]  wait_states;
    logic [31:0] dest;
    logic [31:0] src;
    logic [23:0] addr;
    logic        carry_in;
  } request_t;

  typedef struct packed {
    logic [31:0] result;
    logic        write_back;
    logic        carry_flag;
    logic        zero_flag;
    logic        sign_flag;
    logic        overflow_flag;
    logic [2:0]  length;
    logic [7:0]  states;
    logic [23:0] addr;
  } answer_t;

  localparam logic [15:0] ext_zero  = 16'h0000;
  localparam logic [15:0] ext_one   = 16'hffff;
  localparam logic [7:0]  acc_zero  = 8'h00;
  localparam logic [7:0]  port_cmp_extra  = 8'h01;
  localparam logic [7:0]  sfr_cmp_extra   = 8'h02;
  localparam logic [7:0]  port_logic_extra = 8'h02;
  localparam logic [7:0]  sfr_logic_extra  = 8'h03;
  localparam logic [7:0]  ext_access_extra = 8'h02;
  localparam logic [7:0]  one_state = 8'h01;
  localparam logic [2:0]  one_byte  = 3'h1;
  localparam logic        map_binary = 1'b0;
endpackage

// ==== src/compare_logic_rotate_unit.sv ====
`timescale 1ns/1ps
module compare_logic_rotate_unit (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rst_n,
  // opcode map strap, caught at reset release
  input  wire logic                     source_map_strap,
  // request
  input  wire logic                     req_valid,
  input  wire cmp_logic_pkg::request_t  req,
  // answer
  output logic                          ans_valid,
  output cmp_logic_pkg::answer_t        ans
);

  typedef struct packed {
    logic [2:0] bin_len;
    logic [7:0] bin_st;
    logic [2:0] src_len;
    logic [7:0] src_st;
  } cost_t;

  logic              map_latched;
  logic              source_map;
  logic              strap_meta;
  logic              strap_sync;
  cmp_logic_pkg::answer_t next_ans;

  // base length and states per form, both maps
  function automatic cost_t base_cost(input cmp_logic_pkg::request_t r);
    cost_t c;
    c = '{3'h1, 8'h01, 3'h1, 8'h01};
    if (r.alt_ind_dword) begin
      c = '{3'h4, 8'h04, 3'h3, 8'h03};
    end else if (r.alt_ind_word) begin
      c = '{3'h4, 8'h03, 3'h3, 8'h02};
    end else if (r.alt_direct_long_addr_word) begin
      c = '{3'h5, 8'h04, 3'h4, 8'h03};
    end else begin
      case (r.form)
        cmp_logic_pkg::form_acc_reg:     c = '{3'h1, 8'h01, 3'h2, 8'h02};
        cmp_logic_pkg::form_acc_direct_short_addr:    c = '{3'h2, 8'h01, 3'h2, 8'h01};
        cmp_logic_pkg::form_acc_ind:     c = '{3'h1, 8'h02, 3'h2, 8'h03};
        cmp_logic_pkg::form_acc_imm:     c = '{3'h2, 8'h01, 3'h2, 8'h01};
        cmp_logic_pkg::form_direct_short_addr_acc:    c = '{3'h2, 8'h02, 3'h2, 8'h02};
        cmp_logic_pkg::form_direct_short_addr_imm:    c = '{3'h3, 8'h03, 3'h3, 8'h03};
        cmp_logic_pkg::form_byte_byte:   c = '{3'h3, 8'h02, 3'h2, 8'h01};
        cmp_logic_pkg::form_word_word:   c = '{3'h3, 8'h03, 3'h2, 8'h02};
        cmp_logic_pkg::form_dword_dword: c = '{3'h3, 8'h05, 3'h2, 8'h04};
        cmp_logic_pkg::form_byte_imm:    c = '{3'h4, 8'h03, 3'h3, 8'h02};
        cmp_logic_pkg::form_word_imm:    c = '{3'h5, 8'h04, 3'h4, 8'h03};
        cmp_logic_pkg::form_dword_imm0,
        cmp_logic_pkg::form_dword_imm1:  c = '{3'h5, 8'h06, 3'h4, 8'h05};
        cmp_logic_pkg::form_byte_direct_short_addr:   c = '{3'h4, 8'h03, 3'h3, 8'h02};
        cmp_logic_pkg::form_word_direct_short_addr:   c = '{3'h4, 8'h04, 3'h3, 8'h03};
        cmp_logic_pkg::form_byte_direct_long_addr:  c = '{3'h5, 8'h03, 3'h4, 8'h02};
        default:                         c = '{3'h1, 8'h01, 3'h1, 8'h01};
      endcase
    end
    return c;
  endfunction

  // true when the direct short address form carries a port or sfr penalty
  function automatic logic direct_short_addr_penalised(input cmp_logic_pkg::request_t r);
    return !r.alt_ind_dword && !r.alt_ind_word && !r.alt_direct_long_addr_word &&
           (r.form == cmp_logic_pkg::form_acc_direct_short_addr ||
            r.form == cmp_logic_pkg::form_direct_short_addr_acc ||
            r.form == cmp_logic_pkg::form_direct_short_addr_imm ||
            r.form == cmp_logic_pkg::form_byte_direct_short_addr);
  endfunction

  // true when the operand may live in external memory
  function automatic logic ext_capable(input cmp_logic_pkg::request_t r);
    return r.alt_ind_dword || r.alt_ind_word || r.alt_direct_long_addr_word ||
           (!r.alt_ind_dword && r.form == cmp_logic_pkg::form_byte_direct_long_addr);
  endfunction

  // strap synchroniser, free running so the strap is settled when reset lifts
  always_ff @(posedge mclk) begin
    strap_meta <= source_map_strap;
    strap_sync <= strap_meta;
  end

  // opcode map caught once after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      map_latched <= 1'b0;
      source_map  <= cmp_logic_pkg::map_binary;
    end else if (!map_latched) begin
      map_latched <= 1'b1;
      source_map  <= strap_sync;
    end
  end

  // datapath and timing for one request
  always_comb begin
    cost_t       c;
    logic [31:0] s;
    logic [32:0] diff;
    logic [7:0]  a;
    logic [7:0]  pen;
    logic [7:0]  ext_add;
    logic [31:0] msk;
    logic [4:0]  top;
    c       = base_cost(req);
    s       = req.src;
    diff    = '0;
    a       = req.dest[7:0];
    pen     = acc_zero_w();
    ext_add = acc_zero_w();
    msk     = 32'hffff_ffff;
    top     = 5'h1f;
    next_ans = '0;
    next_ans.addr       = req.addr;
    next_ans.carry_flag = req.carry_in;
    // operand width
    if (req.alt_ind_dword || req.alt_ind_word || (!req.alt_direct_long_addr_word &&
        (req.form == cmp_logic_pkg::form_byte_byte ||
         req.form == cmp_logic_pkg::form_byte_imm || req.form == cmp_logic_pkg::form_byte_direct_short_addr ||
         req.form == cmp_logic_pkg::form_byte_direct_long_addr || req.form <= cmp_logic_pkg::form_direct_short_addr_imm)))
    begin
      msk = 32'h0000_00ff;
      top = 5'h07;
    end else if (!req.alt_direct_long_addr_word && (req.form == cmp_logic_pkg::form_dword_dword ||
                 req.form == cmp_logic_pkg::form_dword_imm0 ||
                 req.form == cmp_logic_pkg::form_dword_imm1)) begin
      msk = 32'hffff_ffff;
      top = 5'h1f;
    end else begin
      msk = 32'h0000_ffff;
      top = 5'h0f;
    end
    // immediate extension
    if (!req.alt_direct_long_addr_word && req.form == cmp_logic_pkg::form_dword_imm0) begin
      s = {cmp_logic_pkg::ext_zero, req.src[15:0]};
    end else if (!req.alt_direct_long_addr_word && req.form == cmp_logic_pkg::form_dword_imm1) begin
      s = {cmp_logic_pkg::ext_one, req.src[15:0]};
    end
    s = s & msk;
    if (req.alt_ind_dword) begin
      next_ans.addr = req.addr; // 24-bit pointer span
    end else begin
      next_ans.addr = {8'h00, req.addr[15:0]};
    end
    // penalties
    if (direct_short_addr_penalised(req)) begin
      if (req.op == cmp_logic_pkg::compare_op) begin
        if (req.space == cmp_logic_pkg::space_port) pen = cmp_logic_pkg::port_cmp_extra;
        if (req.space == cmp_logic_pkg::space_sfr)  pen = cmp_logic_pkg::sfr_cmp_extra;
      end else if (req.form == cmp_logic_pkg::form_direct_short_addr_acc ||
                   req.form == cmp_logic_pkg::form_direct_short_addr_imm) begin
        if (req.space == cmp_logic_pkg::space_port) pen = cmp_logic_pkg::port_logic_extra;
        if (req.space == cmp_logic_pkg::space_sfr)  pen = cmp_logic_pkg::sfr_logic_extra;
      end else begin
        if (req.space == cmp_logic_pkg::space_port) pen = cmp_logic_pkg::port_cmp_extra;
        if (req.space == cmp_logic_pkg::space_sfr)  pen = cmp_logic_pkg::sfr_cmp_extra;
      end
    end
    if (ext_capable(req) && req.space == cmp_logic_pkg::space_ext) begin
      ext_add = {4'h0, req.wait_states} + cmp_logic_pkg::ext_access_extra;
      if (req.alt_direct_long_addr_word) begin
        ext_add = {ext_add[6:0], 1'b0}; // two byte accesses
      end
    end
    if (source_map) begin
      next_ans.length = c.src_len;
      next_ans.states = c.src_st + pen + ext_add;
    end else begin
      next_ans.length = c.bin_len;
      next_ans.states = c.bin_st + pen + ext_add;
    end
    case (req.op)
      cmp_logic_pkg::compare_op: begin
        diff = {1'b0, req.dest & msk} - {1'b0, s};
        next_ans.result     = req.dest;  // destination kept
        next_ans.write_back = 1'b0;
        next_ans.carry_flag = diff[{1'b0, top} + 6'h01]; // borrow, no wrap at 32 bits
        next_ans.zero_flag  = ((diff[31:0] & msk) == 32'h0000_0000);
        next_ans.sign_flag  = diff[top];
        next_ans.overflow_flag = (req.dest[top] ^ s[top]) & (req.dest[top] ^ diff[top]);
      end
      cmp_logic_pkg::bitwise_and_op: begin
        next_ans.result = (req.dest & s) | (req.dest & ~msk);
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::bitwise_or_op: begin
        next_ans.result = req.dest | s;
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::bitwise_xor_op: begin
        next_ans.result = req.dest ^ s;
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::acc_clear_op: begin
        next_ans.result = {req.dest[31:8], cmp_logic_pkg::acc_zero};
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::acc_invert_op: begin
        next_ans.result = {req.dest[31:8], ~a};
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::rotate_left_op: begin
        next_ans.result = {req.dest[31:8], a[6:0], a[7]};
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::rotate_left_carry_op: begin
        next_ans.result = {req.dest[31:8], a[6:0], req.carry_in};
        next_ans.carry_flag = a[7];
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::rotate_right_op: begin
        next_ans.result = {req.dest[31:8], a[0], a[7:1]};
        next_ans.write_back = 1'b1;
      end
      cmp_logic_pkg::rotate_right_carry_op: begin
        next_ans.result = {req.dest[31:8], req.carry_in, a[7:1]};
        next_ans.carry_flag = a[0];
        next_ans.write_back = 1'b1;
      end
      default: begin
        next_ans.result = req.dest;
      end
    endcase
    if (req.op >= cmp_logic_pkg::acc_clear_op) begin
      next_ans.length = cmp_logic_pkg::one_byte;
      next_ans.states = cmp_logic_pkg::one_state;
    end
  end

  function automatic logic [7:0] acc_zero_w();
    return cmp_logic_pkg::acc_zero;
  endfunction

  // registered answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ans_valid <= 1'b0;
      ans       <= '0;
    end else begin
      ans_valid <= req_valid && map_latched;
      if (req_valid && map_latched) begin
        ans <= next_ans;
      end
    end
  end

endmodule
